// ---- shared/mcfr_pkg.sv ----
`default_nettype none
package mcfr_pkg;
   // ==========================================================
   // Sizes and limits
   localparam int ENTRIES = 128;
   localparam int IDX_W = 7;
   localparam int ADDR_W = 16;
   localparam int BITS_W = 20;
   localparam int LEN_W = 9;
   localparam int TOT_W = 16;
   localparam logic [LEN_W-1:0] LEN_MAX = 9'h100;
   localparam logic [TOT_W-1:0] TOTAL_MAX = 16'h0100;
   localparam logic [2:0] CPU_MIN = 3'h1;
   localparam logic [2:0] CPU_MAX = 3'h4;
   localparam int BIT_ALIGN_W = 4;
   localparam logic [IDX_W-1:0] IDX_LAST = 7'h7f;

   // ==========================================================
   // Carriers
   // One refresh entry; cpu_no, win_lo, win_end and sh_base come from the
   // slower shared-area transfer setting with the same entry number.
   typedef struct packed {
      logic is_bit;
      logic [BITS_W-1:0] start;
      logic [LEN_W-1:0] len;
      logic [2:0] cpu_no;
      logic [ADDR_W-1:0] win_lo;
      logic [ADDR_W-1:0] win_end;
      logic [ADDR_W-1:0] sh_base;
   } mcfr_entry_t;

   // One request to a 32-bit memory port; addr is a word address.
   typedef struct packed {
      logic we;
      logic [ADDR_W-1:0] addr;
      logic [31:0] wdata;
   } mcfr_req_t;

   // Word start of an entry; bit devices are addressed in 16-bit groups.
   function automatic logic [ADDR_W-1:0] word_start(input mcfr_entry_t e);
      word_start = e.is_bit ? e.start[BITS_W-1:BIT_ALIGN_W] : e.start[ADDR_W-1:0];
   endfunction

   // Faults that make a written entry unusable on its own.
   function automatic logic entry_fault(input mcfr_entry_t e);
      logic [ADDR_W:0] last;
      last = {1'b0, word_start(e)} + {8'h00, e.len};
      entry_fault = e.len[0] || (e.len > LEN_MAX)
         || (e.is_bit && (e.start[BIT_ALIGN_W-1:0] != 4'h0))
         || (e.cpu_no < CPU_MIN) || (e.cpu_no > CPU_MAX)
         || (e.win_end <= e.win_lo) || (word_start(e) < e.win_lo)
         || (last > {1'b0, e.win_end});
   endfunction
endpackage
`default_nettype wire

// ---- rtl/mcfr_entry_table.sv ----
`timescale 1ns/1ps
`default_nettype none
module mcfr_entry_table
(
   input wire logic clock,
   input wire logic wr_en,
   input wire logic [mcfr_pkg::IDX_W-1:0] wr_idx,
   input wire mcfr_pkg::mcfr_entry_t wr_data,
   input wire logic [mcfr_pkg::IDX_W-1:0] rd_idx,
   output mcfr_pkg::mcfr_entry_t rd_data
);
   import mcfr_pkg::*;

   // ==========================================================
   // Storage
   // Plain array with one synchronous read; holds no reset so it maps to RAM.
   mcfr_entry_t mem [ENTRIES];

   // Write port.
   always_ff @(posedge clock)
   begin
      if (wr_en)
      begin
         mem[wr_idx] <= wr_data;
      end
   end

   // Read port, data valid one cycle after the address.
   always_ff @(posedge clock)
   begin
      rd_data <= mem[rd_idx];
   end
endmodule
`default_nettype wire

// ---- rtl/mcfr_xfer.sv ----
`timescale 1ns/1ps
`default_nettype none
module mcfr_xfer
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic start,
   input wire logic to_dev,
   input wire logic [mcfr_pkg::ADDR_W-1:0] dev_addr,
   input wire logic [mcfr_pkg::ADDR_W-1:0] sh_addr,
   output logic dev_valid,
   output mcfr_pkg::mcfr_req_t dev_req,
   input wire logic [31:0] dev_rdata,
   input wire logic dev_ack,
   output logic sh_valid,
   output mcfr_pkg::mcfr_req_t sh_req,
   input wire logic [31:0] sh_rdata,
   input wire logic sh_ack,
   output logic done
);
   import mcfr_pkg::*;

   typedef enum logic [1:0] {XF_IDLE = 2'b00, XF_READ = 2'b01, XF_WRITE = 2'b11} mcfr_xf_t;
   mcfr_xf_t st_reg;
   logic dir_reg;

   // ==========================================================
   // One 32-bit unit: a whole read, then a whole write of the same two words.
   // The pair never splits, so a 32-bit value is seen either all old or all new.
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         st_reg <= XF_IDLE;
         dir_reg <= 1'b0;
         dev_valid <= 1'b0;
         sh_valid <= 1'b0;
         dev_req <= '0;
         sh_req <= '0;
         done <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         case (st_reg)
            XF_IDLE:
            begin
               if (start)
               begin
                  dir_reg <= to_dev;
                  dev_req <= '{we: 1'b0, addr: dev_addr, wdata: 32'h0000_0000};
                  sh_req <= '{we: 1'b0, addr: sh_addr, wdata: 32'h0000_0000};
                  dev_valid <= ~to_dev;
                  sh_valid <= to_dev;
                  st_reg <= XF_READ;
               end
            end
            XF_READ:
            begin
               if (dir_reg && sh_ack)
               begin
                  sh_valid <= 1'b0;
                  dev_req.we <= 1'b1;
                  dev_req.wdata <= sh_rdata;
                  dev_valid <= 1'b1;
                  st_reg <= XF_WRITE;
               end
               else if (!dir_reg && dev_ack)
               begin
                  dev_valid <= 1'b0;
                  sh_req.we <= 1'b1;
                  sh_req.wdata <= dev_rdata;
                  sh_valid <= 1'b1;
                  st_reg <= XF_WRITE;
               end
            end
            XF_WRITE:
            begin
               if ((dir_reg && dev_ack) || (!dir_reg && sh_ack))
               begin
                  dev_valid <= 1'b0;
                  sh_valid <= 1'b0;
                  done <= 1'b1;
                  st_reg <= XF_IDLE;
               end
            end
            default:
            begin
               st_reg <= XF_IDLE;
            end
         endcase
      end
   end

   // Toward the device, the written word pair is exactly the pair just read from the shared area.
   chk_pair_intact: assert property (@(posedge clock) disable iff (sys_rst)
      (st_reg == XF_READ && dir_reg && sh_ack) |=> (dev_req.wdata == $past(sh_rdata)))
      else $error("pair written differs from pair read");
endmodule
`default_nettype wire

// ---- rtl/mcfr_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module mcfr_top
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic op_tick,
   input wire logic [2:0] self_cpu,
   input wire logic cfg_we,
   input wire logic [mcfr_pkg::IDX_W-1:0] cfg_idx,
   input wire mcfr_pkg::mcfr_entry_t cfg_entry,
   output logic dev_valid,
   output mcfr_pkg::mcfr_req_t dev_req,
   input wire logic [31:0] dev_rdata,
   input wire logic dev_ack,
   output logic sh_valid,
   output mcfr_pkg::mcfr_req_t sh_req,
   input wire logic [31:0] sh_rdata,
   input wire logic sh_ack,
   output logic busy,
   output logic cycle_done,
   output logic overrun,
   output logic cfg_err,
   output logic total_err,
   output logic [mcfr_pkg::TOT_W-1:0] total_words
);
   import mcfr_pkg::*;

   // ==========================================================
   // State machine
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_LOAD = 3'b001,
      ST_EVAL = 3'b011,
      ST_MOVE = 3'b010,
      ST_NEXT = 3'b110,
      ST_SCAN = 3'b100
   } mcfr_state_t;

   mcfr_state_t state_reg;
   logic [IDX_W-1:0] idx_reg;
   logic [IDX_W-1:0] scan_idx_reg;
   logic [IDX_W-1:0] cmp_idx_reg;
   logic cmp_valid_reg;
   logic [IDX_W-1:0] new_idx_reg;
   mcfr_entry_t new_reg;
   logic new_fault_reg;
   logic overlap_reg;
   logic [TOT_W-1:0] sum_reg;
   logic [ENTRIES-1:0] bad_reg;
   logic [LEN_W-1:0] left_reg;
   logic [ADDR_W-1:0] off_reg;
   mcfr_entry_t cur_reg;
   mcfr_entry_t rd_data;
   logic [IDX_W-1:0] rd_idx;
   logic xf_start;
   logic xf_done;
   logic to_dev;
   logic [ADDR_W-1:0] cur_ws;
   mcfr_entry_t act_ent;
   logic [ADDR_W-1:0] unit_off;
   logic [ADDR_W-1:0] dev_addr;
   logic [ADDR_W-1:0] sh_addr;
   logic entry_live;
   logic other_live;
   logic hit;
   logic scan_end;

   // ==========================================================
   // Table and 32-bit mover
   // The table read port is shared: the scan owns it in ST_SCAN, the run
   // otherwise, so the two never compete.
   assign rd_idx = (state_reg == ST_SCAN) ? scan_idx_reg : idx_reg;

   mcfr_entry_table u_table
   (
      .clock(clock),
      .wr_en(cfg_we && state_reg == ST_IDLE),
      .wr_idx(cfg_idx),
      .wr_data(cfg_entry),
      .rd_idx(rd_idx),
      .rd_data(rd_data)
   );

   // In ST_EVAL the entry is still in rd_data, and off_reg lags a start from ST_MOVE by two.
   assign act_ent = (state_reg == ST_EVAL) ? rd_data : cur_reg;
   assign unit_off = (state_reg == ST_MOVE) ? off_reg + 16'h0002 : 16'h0000;
   assign cur_ws = word_start(act_ent);
   assign to_dev = (act_ent.cpu_no != self_cpu);
   assign dev_addr = cur_ws + unit_off;
   assign sh_addr = act_ent.sh_base + (cur_ws - act_ent.win_lo) + unit_off;
   assign entry_live = (rd_data.len != '0) && !bad_reg[idx_reg];
   assign xf_start = (state_reg == ST_EVAL && entry_live)
      || (state_reg == ST_MOVE && xf_done && left_reg > 9'h002);

   mcfr_xfer u_xfer
   (
      .clock(clock),
      .sys_rst(sys_rst),
      .start(xf_start),
      .to_dev(to_dev),
      .dev_addr(dev_addr),
      .sh_addr(sh_addr),
      .dev_valid(dev_valid),
      .dev_req(dev_req),
      .dev_rdata(dev_rdata),
      .dev_ack(dev_ack),
      .sh_valid(sh_valid),
      .sh_req(sh_req),
      .sh_rdata(sh_rdata),
      .sh_ack(sh_ack),
      .done(xf_done)
   );

   // ==========================================================
   // Overlap test for the scan. A compared entry counts when it holds words,
   // is not already marked bad and is not the slot just written.
   assign other_live = cmp_valid_reg && (rd_data.len != '0) && !bad_reg[cmp_idx_reg]
      && (cmp_idx_reg != new_idx_reg);
   assign hit = other_live && (new_reg.len != '0)
      && ({1'b0, word_start(new_reg)} < {1'b0, word_start(rd_data)} + {8'h00, rd_data.len})
      && ({1'b0, word_start(rd_data)} < {1'b0, word_start(new_reg)} + {8'h00, new_reg.len});
   assign scan_end = cmp_valid_reg && (cmp_idx_reg == IDX_LAST);

   // Main sequencing of the run and of the configuration scan.
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         state_reg <= ST_IDLE;
         idx_reg <= '0;
         left_reg <= '0;
         off_reg <= '0;
         cur_reg <= '0;
      end
      else
      begin
         case (state_reg)
            ST_IDLE:
            begin
               idx_reg <= '0;
               if (cfg_we)
               begin
                  state_reg <= ST_SCAN;
               end
               else if (op_tick && !total_err)
               begin
                  state_reg <= ST_LOAD;
               end
            end
            ST_LOAD:
            begin
               state_reg <= ST_EVAL;
            end
            ST_EVAL:
            begin
               cur_reg <= rd_data;
               off_reg <= '0;
               left_reg <= rd_data.len;
               state_reg <= entry_live ? ST_MOVE : ST_NEXT;
            end
            ST_MOVE:
            begin
               if (xf_done)
               begin
                  off_reg <= off_reg + 16'h0002;
                  left_reg <= left_reg - 9'h002;
                  if (left_reg <= 9'h002)
                  begin
                     state_reg <= ST_NEXT;
                  end
               end
            end
            ST_NEXT:
            begin
               idx_reg <= idx_reg + 7'h01;
               state_reg <= (idx_reg == IDX_LAST) ? ST_IDLE : ST_LOAD;
            end
            ST_SCAN:
            begin
               if (scan_end)
               begin
                  state_reg <= ST_IDLE;
               end
            end
            default:
            begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Configuration scan: after each accepted write all 128 slots are read
   // once. The written entry is checked against every live slot, and the
   // live lengths are summed. Checking at write time keeps the per-tick
   // run linear in the table size instead of quadratic.
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         scan_idx_reg <= '0;
         cmp_idx_reg <= '0;
         cmp_valid_reg <= 1'b0;
         new_idx_reg <= '0;
         new_reg <= '0;
         new_fault_reg <= 1'b0;
         overlap_reg <= 1'b0;
         sum_reg <= '0;
      end
      else if (state_reg == ST_IDLE && cfg_we)
      begin
         new_idx_reg <= cfg_idx;
         new_reg <= cfg_entry;
         new_fault_reg <= (cfg_entry.len != '0) && entry_fault(cfg_entry);
         overlap_reg <= 1'b0;
         sum_reg <= '0;
         scan_idx_reg <= '0;
         cmp_valid_reg <= 1'b0;
      end
      else if (state_reg == ST_SCAN)
      begin
         scan_idx_reg <= scan_idx_reg + 7'h01;
         cmp_idx_reg <= scan_idx_reg;
         cmp_valid_reg <= !scan_end && (scan_idx_reg != '0 || !cmp_valid_reg);
         if (hit)
         begin
            overlap_reg <= 1'b1;
         end
         if (other_live)
         begin
            sum_reg <= sum_reg + {7'h00, rd_data.len};
         end
      end
   end

   // Per-slot bad marks; a slot is re-judged each time it is written.
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         bad_reg <= '0;
      end
      else if (state_reg == ST_SCAN && scan_end)
      begin
         bad_reg[new_idx_reg] <= new_fault_reg || overlap_reg || hit;
      end
   end

   // ==========================================================
   // Status outputs, all registered.
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         busy <= 1'b0;
         cycle_done <= 1'b0;
         overrun <= 1'b0;
         cfg_err <= 1'b0;
         total_err <= 1'b0;
         total_words <= '0;
      end
      else
      begin
         busy <= (state_reg != ST_IDLE) || (op_tick && !total_err);
         cycle_done <= (state_reg == ST_NEXT) && (idx_reg == IDX_LAST);
         // A tick during a run or scan is lost; sticky until reset.
         if (op_tick && state_reg != ST_IDLE)
         begin
            overrun <= 1'b1;
         end
         if (state_reg == ST_SCAN && scan_end)
         begin
            cfg_err <= new_fault_reg || overlap_reg || hit;
            // Sum of other live slots plus the new one when it is usable.
            if (new_fault_reg || overlap_reg || hit)
            begin
               total_words <= sum_reg + (other_live ? {7'h00, rd_data.len} : 16'h0000);
               total_err <= (sum_reg + (other_live ? {7'h00, rd_data.len} : 16'h0000))
                  > TOTAL_MAX;
            end
            else
            begin
               total_words <= sum_reg + (other_live ? {7'h00, rd_data.len} : 16'h0000)
                  + {7'h00, new_reg.len};
               total_err <= (sum_reg + (other_live ? {7'h00, rd_data.len} : 16'h0000)
                  + {7'h00, new_reg.len}) > TOTAL_MAX;
            end
         end
      end
   end

   // ==========================================================
   // Checks
   chk_tick_starts: assert property (@(posedge clock) disable iff (sys_rst)
      (state_reg == ST_IDLE && op_tick && !cfg_we && !total_err) |=> (state_reg == ST_LOAD))
      else $error("tick in idle did not start a run");
   chk_total_blocks: assert property (@(posedge clock) disable iff (sys_rst)
      (state_reg == ST_IDLE && total_err) |=> (state_reg != ST_LOAD))
      else $error("run started with total over limit");
   chk_empty_skipped: assert property (@(posedge clock) disable iff (sys_rst)
      (state_reg == ST_EVAL && rd_data.len == '0) |-> (!xf_start ##1 state_reg == ST_NEXT))
      else $error("empty entry was transferred");
   chk_self_outward: assert property (@(posedge clock) disable iff (sys_rst)
      (state_reg == ST_MOVE && xf_start && cur_reg.cpu_no == self_cpu) |=> (dev_valid && !sh_valid))
      else $error("own entry did not read device memory");
   chk_other_inward: assert property (@(posedge clock) disable iff (sys_rst)
      (state_reg == ST_MOVE && xf_start && cur_reg.cpu_no != self_cpu) |=> (sh_valid && !dev_valid))
      else $error("foreign entry did not read shared area");
   chk_len_legal: assert property (@(posedge clock) disable iff (sys_rst)
      (state_reg == ST_EVAL && xf_start) |-> (!rd_data.len[0] && rd_data.len <= LEN_MAX))
      else $error("illegal length transferred");
   chk_bit_aligned: assert property (@(posedge clock) disable iff (sys_rst)
      (state_reg == ST_EVAL && xf_start && rd_data.is_bit) |-> (rd_data.start[3:0] == 4'h0))
      else $error("unaligned bit start transferred");
   chk_cpu_range: assert property (@(posedge clock) disable iff (sys_rst)
      (state_reg == ST_EVAL && xf_start) |-> (rd_data.cpu_no inside {[CPU_MIN:CPU_MAX]}))
      else $error("entry with bad processor number ran");
   chk_in_window: assert property (@(posedge clock) disable iff (sys_rst)
      (state_reg == ST_EVAL && xf_start) |-> (word_start(rd_data) >= rd_data.win_lo))
      else $error("entry start below its window");
   chk_ascending: assert property (@(posedge clock) disable iff (sys_rst)
      (state_reg == ST_NEXT && idx_reg != IDX_LAST) |=> (state_reg == ST_LOAD
         && idx_reg == $past(idx_reg) + 7'h01))
      else $error("entries not taken in ascending order");
   chk_overlap_marks: assert property (@(posedge clock) disable iff (sys_rst)
      (state_reg == ST_SCAN && scan_end && (overlap_reg || hit)) |=> (bad_reg[new_idx_reg] && cfg_err))
      else $error("overlapping entry not marked bad");
   chk_unit_step: assert property (@(posedge clock) disable iff (sys_rst)
      (state_reg == ST_MOVE && xf_done) |=> (off_reg == $past(off_reg) + 16'h0002))
      else $error("transfer unit not two words");

   cov_run_done: cover property (@(posedge clock) disable iff (sys_rst) cycle_done);
   cov_inward: cover property (@(posedge clock) disable iff (sys_rst) sh_valid && !sh_req.we);
   cov_outward: cover property (@(posedge clock) disable iff (sys_rst) dev_valid && !dev_req.we);
   cov_overlap: cover property (@(posedge clock) disable iff (sys_rst) state_reg == ST_SCAN && hit);
endmodule
`default_nettype wire

// ---- tb/mcfr_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module mcfr_mem_model
import mcfr_pkg::*;
#(parameter int LAT = 1)
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic valid,
   input wire mcfr_pkg::mcfr_req_t req,
   output logic [31:0] rdata,
   output logic ack
);
   // ==========================================================
   // Word memory answering after LAT cycles
   logic [15:0] mem [0:2047];
   logic [3:0] cnt_reg;
   logic [10:0] a;

   assign a = req.addr[10:0];

   // Outside an answer and its wait the read bus toggles, so a sample one cycle late sees the old data inverted.
   always @(posedge clock)
   begin
      if (sys_rst || ack || !valid)
      begin
         ack <= 1'b0;
         cnt_reg <= 4'h0;
         rdata <= sys_rst ? 32'h5555_aaaa : ~rdata;
      end
      else if (cnt_reg == 4'(LAT - 1))
      begin
         ack <= 1'b1;
         rdata <= {mem[a + 11'h001], mem[a]};
         if (req.we)
         begin
            mem[a] <= req.wdata[15:0];
            mem[a + 11'h001] <= req.wdata[31:16];
         end
      end
      else
         cnt_reg <= cnt_reg + 4'h1;
   end
endmodule
`default_nettype wire

// ---- tb/tb_multi_cpu_fast_refresh.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_multi_cpu_fast_refresh;
   import mcfr_pkg::*;
   // ==========================================================
   // Signals
   logic clock, sys_rst, op_tick, cfg_we, dev_valid, dev_ack, sh_valid, sh_ack;
   logic busy, cycle_done, overrun, cfg_err, total_err;
   logic [2:0] self_cpu;
   logic [IDX_W-1:0] cfg_idx;
   mcfr_entry_t cfg_entry;
   mcfr_entry_t bad [0:6];
   mcfr_req_t dev_req, sh_req;
   logic [31:0] dev_rdata, sh_rdata;
   logic [TOT_W-1:0] total_words;
   int miscompares, cmp_count, cycles, dev_hits, sh_hits, dones;

   mcfr_top DUT (.clock(clock), .sys_rst(sys_rst), .op_tick(op_tick), .self_cpu(self_cpu),
      .cfg_we(cfg_we), .cfg_idx(cfg_idx), .cfg_entry(cfg_entry), .dev_valid(dev_valid),
      .dev_req(dev_req), .dev_rdata(dev_rdata), .dev_ack(dev_ack), .sh_valid(sh_valid),
      .sh_req(sh_req), .sh_rdata(sh_rdata), .sh_ack(sh_ack), .busy(busy),
      .cycle_done(cycle_done), .overrun(overrun), .cfg_err(cfg_err),
      .total_err(total_err), .total_words(total_words));
   // The shared side answers slower, so the engine must wait on both kinds of memory.
   mcfr_mem_model #(.LAT(1)) dev_mem (.clock(clock), .sys_rst(sys_rst), .valid(dev_valid),
      .req(dev_req), .rdata(dev_rdata), .ack(dev_ack));
   mcfr_mem_model #(.LAT(3)) sh_mem (.clock(clock), .sys_rst(sys_rst), .valid(sh_valid),
      .req(sh_req), .rdata(sh_rdata), .ack(sh_ack));

   // ==========================================================
   // Clock, access counters and hang limit
   initial
   begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   always @(posedge clock)
   begin
      cycles++;
      if (dev_valid && dev_ack)
         dev_hits++;
      if (sh_valid && sh_ack)
         sh_hits++;
      if (cycle_done)
         dones++;
      if (cycles > 40000)
      begin
         miscompares++;
         results();
      end
   end

   // ==========================================================
   // Tasks
   task automatic results();
      $display("comparisons %0d, miscompares %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value %s: expected %h, seen %h", name, exp, got);
      end
   endtask

   task automatic idle_wait(input int max);
      @(posedge clock); // Busy rises only one edge after a write is taken.
      #1;
      repeat (max)
         if (busy)
         begin
            @(posedge clock);
            #1;
         end
   endtask

   task automatic wr_entry(input int idx, input mcfr_entry_t e);
      @(posedge clock);
      #1;
      cfg_we = 1'b1;
      cfg_idx = idx[IDX_W-1:0];
      cfg_entry = e;
      @(posedge clock);
      #1;
      cfg_we = 1'b0;
      idle_wait(300);
   endtask

   task automatic tick();
      @(posedge clock);
      #1;
      op_tick = 1'b1;
      @(posedge clock);
      #1;
      op_tick = 1'b0;
   endtask

   function automatic mcfr_entry_t mk(input logic b, input logic [19:0] s,
      input logic [8:0] n, input logic [2:0] c, input logic [15:0] lo,
      input logic [15:0] hi, input logic [15:0] base);
      mk = '{b, s, n, c, lo, hi, base};
   endfunction

   // ==========================================================
   // Main sequence
   initial
   begin
      miscompares = 0;
      cmp_count = 0;
      cycles = 0;
      dev_hits = 0;
      sh_hits = 0;
      dones = 0;
      sys_rst = 1'b1;
      op_tick = 1'b0;
      cfg_we = 1'b0;
      cfg_idx = '0;
      cfg_entry = '0;
      self_cpu = 3'h1;
      for (int i = 0; i < 2048; i++)
      begin
         dev_mem.mem[i] = 16'(i);
         sh_mem.mem[i] = ~16'(i);
      end
      repeat (6) @(posedge clock);
      #1;
      sys_rst = 1'b0;
      chk("flags", 32'h0, {busy, cycle_done, overrun, cfg_err, total_err});
      for (int i = 0; i < 128; i++)
         wr_entry(i, mk(0, 0, 0, 1, 0, 16'h0100, 0));
      wr_entry(0, mk(0, 20'h0_0010, 4, 1, 0, 16'h0100, 16'h0200));
      wr_entry(1, mk(0, 20'h0_0040, 2, 2, 0, 16'h0100, 16'h0300));
      wr_entry(2, mk(1, 20'h0_0800, 2, 3, 0, 16'h0100, 16'h0400));
      chk("cfg_err", 32'h0, cfg_err);
      chk("total_words", 32'h8, total_words);
      tick();
      idle_wait(3000);
      chk("cycle_done count", 32'h1, dones);
      chk("device accesses", 32'h4, dev_hits);
      chk("shared accesses", 32'h4, sh_hits);
      for (int i = 0; i < 4; i++)
         chk("shared word", 32'(16'h0010 + i), sh_mem.mem[16'h0210 + i]);
      for (int i = 0; i < 2; i++)
      begin
         chk("device word", {16'h0000, ~16'(16'h0340 + i)}, dev_mem.mem[16'h0040 + i]);
         chk("bit word", {16'h0000, ~16'(16'h0480 + i)}, dev_mem.mem[16'h0080 + i]);
      end
      bad[0] = mk(0, 20'h0_0100, 3, 2, 0, 16'h0400, 0);
      bad[1] = mk(0, 20'h0_0100, 9'h102, 2, 0, 16'h0400, 0);
      bad[2] = mk(1, 20'h0_1005, 2, 2, 0, 16'h0400, 0);
      bad[3] = mk(0, 20'h0_0100, 2, 5, 0, 16'h0400, 0);
      bad[4] = mk(0, 20'h0_0012, 2, 1, 0, 16'h0100, 0);
      bad[5] = mk(0, 20'h0_00fe, 4, 2, 0, 16'h0100, 0);
      bad[6] = mk(0, 20'h0_0100, 2, 2, 16'h0010, 16'h0010, 0);
      for (int i = 0; i < 7; i++)
      begin
         wr_entry(3, bad[i]);
         chk("cfg_err fault", 32'h1, cfg_err);
      end
      wr_entry(3, mk(0, 0, 0, 1, 0, 16'h0100, 0));
      wr_entry(4, mk(0, 20'h0_0400, 9'h100, 2, 16'h0400, 16'h0600, 16'h0600));
      chk("total_err", 32'h1, total_err);
      tick();
      chk("busy refused", 32'h0, busy);
      wr_entry(4, mk(0, 20'h0_0400, 9'h0f8, 2, 16'h0400, 16'h0600, 16'h0600));
      chk("total at limit", 32'h100, {total_err, total_words});
      tick();
      idle_wait(5000);
      chk("shared accesses", 32'h84, sh_hits);
      chk("last word", {16'h0000, ~16'h06f7}, dev_mem.mem[16'h04f7]);
      tick();
      tick();
      chk("overrun", 32'h1, overrun);
      idle_wait(5000);
      chk("cycle_done count", 32'h3, dones);
      results();
   end
endmodule
`default_nettype wire
